/* File: hdl/ttc_touch_threshold_compare.sv */
// Touch threshold compare: threshold registers, derived levels and status flags
//
// How it works
// - Touch flagged when a sensor's delta exceeds its stored threshold.
// - Button broadcast set: writing sensor 1 threshold also loads 31h-36h.
// - Group broadcast set: writing 30h also loads 37h and 40h.
// - Each button threshold stays directly writable; later broadcast alone overrides.
// - Up and down thresholds written alone; group writes leave them untouched.
// - Delta above noise level but not above touch is noise, excluded.
// - Two-bit code picks noise level: 6.25, 12.5, 25 or 50 percent.
// - Register 38h holds noise codes for sensors 1-4, resets AAh.
// - Register 39h holds grouped code and sensors 5-7 noise codes.
// - Delta above lid level sets the sensor's lid status bit.
// - Lid level derived from touch threshold by the same fraction code.
// - Register 3Ah holds lid codes for sensors 1-4, resets AAh.
// - Register 3Bh holds lid codes for sensors 5-8.
// - Register 3Ch holds lid codes for sensors 9-12.
// - Register 3Dh holds sensors 13-14 lid codes, upper bits zero, resets 0Ah.
// - Recalibration config bit 7 button broadcast default 1; bit 6 group, 0.
// - Threshold registers are seven bits, bit 7 reads zero, reset 40h.
//
// Register map
//   2Fh  recalibration config, bit 7 button broadcast, bit 6 group broadcast
//        the other bits are stored and read back but steer nothing here
//   30h  sensor 1 threshold, the source of both broadcasts
//   31h  sensor 2 threshold
//   32h  sensor 3 threshold
//   33h  sensor 4 threshold
//   34h  sensor 5 threshold
//   35h  sensor 6 threshold
//   36h  sensor 7 threshold
//   37h  group threshold, shared by grouped sensors 8 to 13
//   38h  noise codes, sensors 1 to 4
//   39h  noise codes, sensors 5 to 7 and the grouped sensors
//   3Ah  lid codes, sensors 1 to 4
//   3Bh  lid codes, sensors 5 to 8
//   3Ch  lid codes, sensors 9 to 12
//   3Dh  lid codes, sensors 13 and 14, upper nibble reads zero
//   40h  sensor fourteen threshold
//   41h  up threshold, plain storage
//   42h  down threshold, plain storage
//   50h  touch flags, sensors 1 to 7
//   51h  touch flags, sensors 8 to 14
//   52h  lid flags, sensors 1 to 7
//   53h  lid flags, sensors 8 to 14
//   54h  noise flags, bit 7 any of sensors 8 to 14, bits 6-0 buttons
//   55h  sticky event status, write one to clear
//   56h  event mask, same layout as the status
//
// Event status bits
//   bit 0  a touch was seen in a sample
//   bit 1  a lid level was crossed in a sample
//   bit 2  a noise spike was seen in a sample
//   An event in the same cycle as its clear keeps the bit set.
//
// Timing
//   A write lands at the edge that samples the strobe.
//   Read data stand for the one cycle after the strobe, zero otherwise.
//   A valid sample gives its flags at the next edge.
//   Touch, lid and noise flags hold until the next valid sample.
//   The recalibration flag is a one-cycle pulse per clean sample.
//   The interrupt follows the status and mask registers directly.
//
// Hazards and limits
//   Clock enable low freezes every register, read data included.
//   Strobes seen while the clock enable is low are lost.
//   Derived levels are truncated shifts, so small thresholds give zero.
//   A zero level flags any non-zero delta as noise or lid.
//   Grouped noise flags collapse into one bit for all grouped sensors.
//   Broadcasts copy the seven stored bits, bit 7 is always dropped.
//   A direct write to 31h-36h sticks until the next broadcast write.
//   Group writes leave the up and down thresholds alone.
//   Unmapped writes are ignored and unmapped reads give zero.
//
// Structure
//   All state sits in one packed struct.
//   One combinational process builds the next copy.
//   One clocked process registers it, with reset and enable.
//   Derived levels are combinational from the stored registers.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ttc_touch_threshold_compare (
  input  wire logic                 ref_clk,
  input  wire logic                 srst,
  input  wire logic                 clkEn,
  input  wire logic [7:0]           regAddr,
  input  wire logic [7:0]           regWrData,
  input  wire logic                 regWrStb,
  input  wire logic                 regRdStb,
  output logic      [7:0]           regRdData,
  input  wire ttc_pkg::ttc_sample_t sampleIn,
  output ttc_pkg::ttc_result_t      resultOut,
  output logic                      recalSampleOk,
  output logic                      irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0]           recalCfg;
    logic [13:0][6:0]     thr;        // 0..6 buttons, 7 group, 13 sensor fourteen
    logic [6:0]           upThr;
    logic [6:0]           downThr;
    logic [7:0]           noiseLo;
    logic [7:0]           noiseHi;
    logic [7:0]           lidA;
    logic [7:0]           lidB;
    logic [7:0]           lidC;
    logic [3:0]           lidD;
    logic [13:0]          lidStatus;
    ttc_pkg::ttc_result_t result;
    logic                 recalOk;
    logic [2:0]           irqStatus;
    logic [2:0]           irqMask;
    logic [7:0]           rdData;
  } ttc_state_t;

  ttc_state_t state_ff;
  ttc_state_t nxt_state;

  ////////////////////////////////////////////////////////////////////////////
  // Derived levels

  function automatic logic [6:0] ttcFrac(input logic [6:0] t, input logic [1:0] code);
    logic [6:0] r;
    r = 7'h00;
    unique case (code)
      2'b00: r = t >> 4;
      2'b01: r = t >> 3;
      2'b10: r = t >> 2;
      2'b11: r = t >> 1;
    endcase
    return r;
  endfunction

  logic [6:0][1:0]  noiseCode;
  logic [13:0][1:0] lidCode;
  logic [13:0][6:0] sensThr;
  logic [6:0][6:0]  noiseLvl;
  logic [1:0]       groupNoiseCode;
  logic [6:0]       groupNoiseLvl;
  logic [13:0][6:0] lidLvl;

  assign noiseCode[0] = state_ff.noiseLo[1:0];
  assign noiseCode[1] = state_ff.noiseLo[3:2];
  assign noiseCode[2] = state_ff.noiseLo[5:4];
  assign noiseCode[3] = state_ff.noiseLo[7:6];
  // noise codes sensors 5-7 and group
  assign noiseCode[4]   = state_ff.noiseHi[1:0];
  assign noiseCode[5]   = state_ff.noiseHi[3:2];
  assign noiseCode[6]   = state_ff.noiseHi[5:4];
  assign groupNoiseCode = state_ff.noiseHi[7:6];

  // lid codes 1-4, lid codes 5-8
  assign lidCode[3:0]   = state_ff.lidA;
  assign lidCode[7:4]   = state_ff.lidB;
  // lid codes 9-12, lid codes 13-14
  assign lidCode[11:8]  = state_ff.lidC;
  assign lidCode[13:12] = state_ff.lidD;

  // Grouped sensors 8-13 use the group level, sensor fourteen its own
  always_comb begin
    for (int i = 0; i < ttc_pkg::NUM_SENSORS; i++) begin
      if (i < ttc_pkg::NUM_BUTTONS) begin
        sensThr[i] = state_ff.thr[i];
      end else if (i == ttc_pkg::NUM_SENSORS - 1) begin
        sensThr[i] = state_ff.thr[13];
      end else begin
        sensThr[i] = state_ff.thr[7];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < ttc_pkg::NUM_BUTTONS; i++) begin
      noiseLvl[i] = ttcFrac(state_ff.thr[i], noiseCode[i]);
    end
  end
  assign groupNoiseLvl = ttcFrac(state_ff.thr[7], groupNoiseCode);

  always_comb begin
    for (int i = 0; i < ttc_pkg::NUM_SENSORS; i++) begin
      lidLvl[i] = ttcFrac(sensThr[i], lidCode[i]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register write decode

  logic wrThrFirst;
  logic buttonBcast;
  logic groupBcast;

  assign wrThrFirst  = regWrStb && (regAddr == ttc_pkg::ADDR_THR_FIRST);
  assign buttonBcast = state_ff.recalCfg[ttc_pkg::BIT_BUTTON_BC];
  assign groupBcast  = state_ff.recalCfg[ttc_pkg::BIT_GROUP_BC];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [13:0] touchNow;
    logic [13:0] lidNow;
    logic [6:0]  noiseNow;
    logic        groupNoiseNow;
    logic [2:0]  irqSet;
    logic [2:0]  irqClr;
    touchNow      = '0;
    lidNow        = '0;
    noiseNow      = '0;
    groupNoiseNow = 1'b0;
    irqSet        = '0;
    irqClr        = '0;
    nxt_state     = state_ff;

    // Register writes
    if (regWrStb) begin
      unique case (regAddr)
        ttc_pkg::ADDR_RECAL_CFG: nxt_state.recalCfg = regWrData;
        ttc_pkg::ADDR_THR_GROUP: nxt_state.thr[7]   = regWrData[6:0];
        ttc_pkg::ADDR_THR_S14:   nxt_state.thr[13]  = regWrData[6:0];
        ttc_pkg::ADDR_UP_THR:    nxt_state.upThr    = regWrData[6:0];
        ttc_pkg::ADDR_DOWN_THR:  nxt_state.downThr  = regWrData[6:0];
        ttc_pkg::ADDR_NOISE_LO:  nxt_state.noiseLo  = regWrData;
        ttc_pkg::ADDR_NOISE_HI:  nxt_state.noiseHi  = regWrData;
        ttc_pkg::ADDR_LID_A:     nxt_state.lidA     = regWrData;
        ttc_pkg::ADDR_LID_B:     nxt_state.lidB     = regWrData;
        ttc_pkg::ADDR_LID_C:     nxt_state.lidC     = regWrData;
        ttc_pkg::ADDR_LID_D:     nxt_state.lidD     = regWrData[3:0];
        ttc_pkg::ADDR_IRQ_MASK:  nxt_state.irqMask  = regWrData[2:0];
        ttc_pkg::ADDR_IRQ_ST:    irqClr             = regWrData[2:0];
        default: begin
          if (regAddr >= ttc_pkg::ADDR_THR_FIRST && regAddr <= ttc_pkg::ADDR_THR_LAST) begin
            nxt_state.thr[3'(regAddr - ttc_pkg::ADDR_THR_FIRST)] = regWrData[6:0];
          end
        end
      endcase
    end

    if (wrThrFirst && buttonBcast) begin
      for (int i = 1; i < ttc_pkg::NUM_BUTTONS; i++) begin
        nxt_state.thr[i] = regWrData[6:0];
      end
    end
    if (wrThrFirst && groupBcast) begin
      nxt_state.thr[7]  = regWrData[6:0];
      nxt_state.thr[13] = regWrData[6:0];
    end

    // Sample comparison
    nxt_state.result.valid = sampleIn.valid;
    if (sampleIn.valid) begin
      for (int i = 0; i < ttc_pkg::NUM_SENSORS; i++) begin
        touchNow[i] = sampleIn.delta[i] > sensThr[i];
        lidNow[i]   = sampleIn.delta[i] > lidLvl[i];
      end
      for (int i = 0; i < ttc_pkg::NUM_BUTTONS; i++) begin
        noiseNow[i] = (sampleIn.delta[i] > noiseLvl[i]) && !touchNow[i];
      end
      for (int i = ttc_pkg::NUM_BUTTONS; i < ttc_pkg::NUM_SENSORS; i++) begin
        if ((sampleIn.delta[i] > groupNoiseLvl) && !touchNow[i]) begin
          groupNoiseNow = 1'b1;
        end
      end
      nxt_state.result.touch      = touchNow;
      nxt_state.result.lid        = lidNow;
      nxt_state.result.noise      = noiseNow;
      nxt_state.result.groupNoise = groupNoiseNow;
      nxt_state.lidStatus         = lidNow;
      nxt_state.recalOk           = !(|noiseNow || groupNoiseNow);
      irqSet[ttc_pkg::IRQ_TOUCH]  = |touchNow;
      irqSet[ttc_pkg::IRQ_LID]    = |lidNow;
      irqSet[ttc_pkg::IRQ_NOISE]  = |noiseNow || groupNoiseNow;
    end else begin
      nxt_state.recalOk = 1'b0;
    end

    // Sticky status: set wins over clear
    nxt_state.irqStatus = (state_ff.irqStatus & ~irqClr) | irqSet;

    // Read data, one cycle after the strobe
    nxt_state.rdData = ttc_pkg::RD_UNMAPPED;
    if (regRdStb) begin
      unique case (regAddr)
        ttc_pkg::ADDR_RECAL_CFG: nxt_state.rdData = state_ff.recalCfg;
        ttc_pkg::ADDR_THR_GROUP: nxt_state.rdData = {1'b0, state_ff.thr[7]};
        ttc_pkg::ADDR_THR_S14:   nxt_state.rdData = {1'b0, state_ff.thr[13]};
        ttc_pkg::ADDR_UP_THR:    nxt_state.rdData = {1'b0, state_ff.upThr};
        ttc_pkg::ADDR_DOWN_THR:  nxt_state.rdData = {1'b0, state_ff.downThr};
        ttc_pkg::ADDR_NOISE_LO:  nxt_state.rdData = state_ff.noiseLo;
        ttc_pkg::ADDR_NOISE_HI:  nxt_state.rdData = state_ff.noiseHi;
        ttc_pkg::ADDR_LID_A:     nxt_state.rdData = state_ff.lidA;
        ttc_pkg::ADDR_LID_B:     nxt_state.rdData = state_ff.lidB;
        ttc_pkg::ADDR_LID_C:     nxt_state.rdData = state_ff.lidC;
        ttc_pkg::ADDR_LID_D:     nxt_state.rdData = {4'h0, state_ff.lidD};
        ttc_pkg::ADDR_TOUCH_LO:  nxt_state.rdData = {1'b0, state_ff.result.touch[6:0]};
        ttc_pkg::ADDR_TOUCH_HI:  nxt_state.rdData = {1'b0, state_ff.result.touch[13:7]};
        ttc_pkg::ADDR_LIDST_LO:  nxt_state.rdData = {1'b0, state_ff.lidStatus[6:0]};
        ttc_pkg::ADDR_LIDST_HI:  nxt_state.rdData = {1'b0, state_ff.lidStatus[13:7]};
        ttc_pkg::ADDR_NOISE_ST:  nxt_state.rdData = {state_ff.result.groupNoise,
                                                     state_ff.result.noise};
        ttc_pkg::ADDR_IRQ_ST:    nxt_state.rdData = {5'h00, state_ff.irqStatus};
        ttc_pkg::ADDR_IRQ_MASK:  nxt_state.rdData = {5'h00, state_ff.irqMask};
        default: begin
          if (regAddr >= ttc_pkg::ADDR_THR_FIRST && regAddr <= ttc_pkg::ADDR_THR_LAST) begin
            nxt_state.rdData = {1'b0, state_ff.thr[3'(regAddr - ttc_pkg::ADDR_THR_FIRST)]};
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Reset, clock enable hold, else update
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_ff.recalCfg  <= ttc_pkg::RST_RECAL_CFG;
      for (int i = 0; i < ttc_pkg::NUM_SENSORS; i++) begin
        state_ff.thr[i]  <= ttc_pkg::RST_THRESHOLD;
      end
      state_ff.upThr     <= ttc_pkg::RST_THRESHOLD;
      state_ff.downThr   <= ttc_pkg::RST_THRESHOLD;
      state_ff.noiseLo   <= ttc_pkg::RST_FRAC_FULL;
      state_ff.noiseHi   <= ttc_pkg::RST_FRAC_FULL;
      state_ff.lidA      <= ttc_pkg::RST_FRAC_FULL;
      state_ff.lidB      <= ttc_pkg::RST_FRAC_FULL;
      state_ff.lidC      <= ttc_pkg::RST_FRAC_FULL;
      state_ff.lidD      <= ttc_pkg::RST_LID_D[3:0];
      state_ff.lidStatus <= '0;
      state_ff.result    <= '0;
      state_ff.recalOk   <= 1'b0;
      state_ff.irqStatus <= ttc_pkg::RST_IRQ;
      state_ff.irqMask   <= ttc_pkg::RST_IRQ;
      state_ff.rdData    <= ttc_pkg::RD_UNMAPPED;
    end else if (clkEn) begin
      state_ff <= nxt_state;
    end
  end

  // Outputs
  assign regRdData     = state_ff.rdData;
  assign resultOut     = state_ff.result;
  assign recalSampleOk = state_ff.recalOk;
  assign irq           = |(state_ff.irqStatus & state_ff.irqMask);

endmodule
`default_nettype wire

/* File: hdl/ttc_pkg.sv */
// Package: register map, field layout, reset values and carriers for touch threshold compare
package ttc_pkg;
  localparam int          NUM_SENSORS    = 14;
  localparam int          NUM_BUTTONS    = 7;
  // Register offsets
  localparam logic [7:0]  ADDR_RECAL_CFG = 8'h2F;
  localparam logic [7:0]  ADDR_THR_FIRST = 8'h30;
  localparam logic [7:0]  ADDR_THR_LAST  = 8'h36;
  localparam logic [7:0]  ADDR_THR_GROUP = 8'h37;
  localparam logic [7:0]  ADDR_NOISE_LO  = 8'h38;
  localparam logic [7:0]  ADDR_NOISE_HI  = 8'h39;
  localparam logic [7:0]  ADDR_LID_A     = 8'h3A;
  localparam logic [7:0]  ADDR_LID_B     = 8'h3B;
  localparam logic [7:0]  ADDR_LID_C     = 8'h3C;
  localparam logic [7:0]  ADDR_LID_D     = 8'h3D;
  localparam logic [7:0]  ADDR_THR_S14   = 8'h40;
  localparam logic [7:0]  ADDR_UP_THR    = 8'h41;
  localparam logic [7:0]  ADDR_DOWN_THR  = 8'h42;
  localparam logic [7:0]  ADDR_TOUCH_LO  = 8'h50;
  localparam logic [7:0]  ADDR_TOUCH_HI  = 8'h51;
  localparam logic [7:0]  ADDR_LIDST_LO  = 8'h52;
  localparam logic [7:0]  ADDR_LIDST_HI  = 8'h53;
  localparam logic [7:0]  ADDR_NOISE_ST  = 8'h54;
  localparam logic [7:0]  ADDR_IRQ_ST    = 8'h55;
  localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h56;
  // Field positions
  localparam int          BIT_BUTTON_BC  = 7;
  localparam int          BIT_GROUP_BC   = 6;
  localparam int          IRQ_TOUCH      = 0;
  localparam int          IRQ_LID        = 1;
  localparam int          IRQ_NOISE      = 2;
  // Reset values
  localparam logic [7:0]  RST_RECAL_CFG  = 8'h93;
  localparam logic [6:0]  RST_THRESHOLD  = 7'h40;
  localparam logic [7:0]  RST_FRAC_FULL  = 8'hAA;
  localparam logic [7:0]  RST_LID_D      = 8'h0A;
  localparam logic [2:0]  RST_IRQ        = 3'h0;
  localparam logic [7:0]  RD_UNMAPPED    = 8'h00;

  // One sample of measured deltas
  typedef struct packed {
    logic                 valid;
    logic [13:0][6:0]     delta;
  } ttc_sample_t;

  // Per-sample comparison results
  typedef struct packed {
    logic                 valid;
    logic [13:0]          touch;
    logic [13:0]          lid;
    logic [6:0]           noise;
    logic                 groupNoise;
  } ttc_result_t;
endpackage

/* File: bench/ttc_touch_threshold_compare_checker.sv */
// Checker: port-level assertions for touch threshold compare
`timescale 1ns/1ps
`default_nettype none
module ttc_checker (
  input wire logic                 ref_clk,
  input wire logic                 srst,
  input wire logic                 clkEn,
  input wire logic [7:0]           regAddr,
  input wire logic [7:0]           regWrData,
  input wire logic                 regWrStb,
  input wire logic                 regRdStb,
  input wire logic [7:0]           regRdData,
  input wire ttc_pkg::ttc_sample_t sampleIn,
  input wire ttc_pkg::ttc_result_t resultOut,
  input wire logic                 recalSampleOk,
  input wire logic                 irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  ///////////////////////////////////////////////////////////////////////////
  // Read data, sample results and interrupt
  rd_idle_a: assert property ($past(clkEn) && !$past(regRdStb) |-> regRdData == 8'h00)
    else $error("read data not idle");
  zero_delta_a: assert property (clkEn && sampleIn.valid && sampleIn.delta == '0
    |=> resultOut.touch == 14'h0 && resultOut.lid == 14'h0) else $error("flag on zero delta");
  lid_cover_a: assert property (resultOut.valid |-> (resultOut.touch & ~resultOut.lid) == 14'h0)
    else $error("touch without lid");
  noise_excl_a: assert property (resultOut.valid |-> (resultOut.noise & resultOut.touch[6:0]) == 7'h0)
    else $error("noise with touch");
  recal_ok_a: assert property (resultOut.valid
    |-> recalSampleOk == !(|{resultOut.groupNoise, resultOut.noise})) else $error("recal flag wrong");
  valid_pulse_a: assert property (clkEn |=> resultOut.valid == $past(sampleIn.valid))
    else $error("result valid wrong");
  result_held_a: assert property (clkEn && !sampleIn.valid
    |=> $stable(resultOut.touch) && $stable(resultOut.lid) && !recalSampleOk) else $error("not held");
  irq_hold_a: assert property (irq && !(clkEn && regWrStb && (regAddr == ttc_pkg::ADDR_IRQ_ST ||
    regAddr == ttc_pkg::ADDR_IRQ_MASK)) |=> irq)
    else $error("irq dropped");
  // Main scenarios reached
  cover property (resultOut.valid && |resultOut.touch);
  cover property (resultOut.valid && |resultOut.noise);
  cover property (irq);
endmodule
bind ttc_touch_threshold_compare ttc_checker ttc_checker_inst (.ref_clk(ref_clk), .srst(srst),
  .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
  .regRdStb(regRdStb), .regRdData(regRdData), .sampleIn(sampleIn), .resultOut(resultOut),
  .recalSampleOk(recalSampleOk), .irq(irq));
`default_nettype wire

/* File: bench/ttc_touch_threshold_compare_bench.sv */
// Bench: touch threshold compare checked against a register-level model
`timescale 1ns/1ps
`default_nettype none
module ttc_touch_threshold_compare_bench;
  logic                 ref_clk, srst, clkEn, regWrStb, regRdStb, recalSampleOk, irq;
  logic [7:0]           regAddr, regWrData, regRdData;
  ttc_pkg::ttc_sample_t sampleIn;
  ttc_pkg::ttc_result_t resultOut;
  logic [7:0]           mreg [256];
  logic [13:0][6:0]     dv;
  logic [31:0]          seed, r;
  int                   errCount, checksDone, cyc;

  ttc_touch_threshold_compare ttc_touch_threshold_compare_inst (.ref_clk(ref_clk), .srst(srst),
    .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .sampleIn(sampleIn), .resultOut(resultOut),
    .recalSampleOk(recalSampleOk), .irq(irq));

  // Clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errCount++;
      endOfTest();
    end
  end
  ///////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic bit mapped(input logic [7:0] a);
    return a inside {[8'h2F:8'h3D], [8'h40:8'h42], [8'h50:8'h56]};
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Model of a register write, broadcasts included
  task automatic mwr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] t;
    t = a inside {[8'h30:8'h37], [8'h40:8'h42]} ? {1'b0, d[6:0]} : d;
    if (a == 8'h3D) t = d & 8'h0F;
    if (a == 8'h55) t = mreg[8'h55] & ~d;
    if (a == 8'h56) t = d & 8'h07;
    if (mapped(a) && !(a inside {[8'h50:8'h54]})) mreg[a] = t;
    if (a == 8'h30 && mreg[8'h2F][7]) for (int i = 8'h31; i <= 8'h36; i++) mreg[i] = t;
    if (a == 8'h30 && mreg[8'h2F][6]) begin
      mreg[8'h37] = t;
      mreg[8'h40] = t;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic en = 1'b1);
    @(posedge ref_clk);
    clkEn <= en;
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    clkEn <= 1'b1;
    regWrStb <= 1'b0;
    if (en) mwr(a, d);
    #1 cmp(irq, |(mreg[8'h55][2:0] & mreg[8'h56][2:0]));
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1 cmp(regRdData, mapped(a) ? mreg[a] : 8'h00);
  endtask
  task automatic chkAll();
    for (int a = 8'h2F; a <= 8'h55; a++) rd(a[7:0]);
    rd(8'h60);
  endtask
  // Sample with expected flags from the model
  task automatic smp(input logic [13:0][6:0] d);
    logic [13:0] t, l;
    logic [7:0]  nz;
    int          th, c;
    nz = 8'h00;
    for (int i = 0; i < 14; i++) begin
      th = i < 7 ? mreg[8'h30 + i] : (i < 13 ? mreg[8'h37] : mreg[8'h40]);
      t[i] = d[i] > th;
      l[i] = d[i] > (th >> (4 - ((mreg[8'h3A + i / 4] >> (2 * (i % 4))) & 3)));
      c = i < 7 ? (mreg[8'h38 + i / 4] >> (2 * (i % 4))) & 3 : mreg[8'h39] >> 6;
      th = i < 7 ? th : mreg[8'h37];
      if (i < 7) nz[i] = d[i] > (th >> (4 - c)) && !t[i];
      else nz[7] = nz[7] | (d[i] > (th >> (4 - c)) && !t[i]);
    end
    @(posedge ref_clk);
    sampleIn <= {1'b1, d};
    @(posedge ref_clk);
    sampleIn.valid <= 1'b0;
    #1 cmp(resultOut.touch, t);
    cmp(resultOut.lid, l);
    cmp({resultOut.groupNoise, resultOut.noise}, nz);
    cmp(recalSampleOk, nz == 8'h00);
    mreg[8'h50] = {1'b0, t[6:0]};
    mreg[8'h51] = {1'b0, t[13:7]};
    mreg[8'h52] = {1'b0, l[6:0]};
    mreg[8'h53] = {1'b0, l[13:7]};
    mreg[8'h54] = nz;
    mreg[8'h55] = mreg[8'h55] | {5'h00, |nz, |l, |t};
    cmp(irq, |(mreg[8'h55][2:0] & mreg[8'h56][2:0]));
  endtask
  task automatic endOfTest();
    if (errCount == 0 && checksDone > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ///////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 32'h0000_7343;
    {srst, clkEn, regWrStb, regRdStb, regAddr, regWrData} = {2'b11, 2'b00, 16'h0000};
    sampleIn = '0;
    {errCount, checksDone, cyc} = '0;
    foreach (mreg[i]) mreg[i] = (i inside {[8'h30:8'h37], [8'h40:8'h42]}) ? 8'h40 : 8'h00;
    for (int i = 8'h38; i <= 8'h3C; i++) mreg[i] = 8'hAA;
    mreg[8'h3D] = 8'h0A;
    mreg[8'h2F] = 8'h93;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    clkEn <= 1'b1;
    chkAll();
    wr(8'h30, 8'h25);
    chkAll();
    wr(8'h2F, 8'hD3);
    wr(8'h30, 8'h9A);
    chkAll();
    wr(8'h33, 8'h11);
    wr(8'h41, 8'h05);
    wr(8'h42, 8'h06);
    wr(8'h37, 8'h22);
    wr(8'h30, 8'h50, 1'b0);
    chkAll();
    wr(8'h2F, 8'h13);
    wr(8'h30, 8'h7F);
    chkAll();
    wr(8'h2F, 8'hC3);
    wr(8'h30, 8'h40);
    wr(8'h56, 8'h07);
    smp('0);
    // Every fraction code at its boundaries
    for (int c = 0; c < 4; c++) begin
      for (int a = 8'h38; a <= 8'h3D; a++) wr(a[7:0], 8'(8'h55 * c));
      for (int k = 0; k < 4; k++) smp({14{7'(k < 2 ? (8'h40 >> (4 - c)) + k : 8'h3E + k)}});
      wr(8'h56, 8'h00);
      wr(8'h55, 8'h07);
      wr(8'h56, 8'h07);
    end
    // Random registers and deltas
    for (int n = 0; n < 300; n++) begin
      r = xs();
      if (r[3]) wr(r[4] ? 8'(8'h55 + r[5]) : 8'(8'h2F + r[15:8] % 17), r[31:24]);
      foreach (dv[i]) begin
        r = xs();
        dv[i] = r[6:0];
      end
      smp(dv);
    end
    chkAll();
    endOfTest();
  end
endmodule
`default_nettype wire
